// ===== design/cmd_unit_params.svh
// offsets, codes, field positions and constants of the command unit
`ifndef CMD_UNIT_PARAMS_SVH
`define CMD_UNIT_PARAMS_SVH

// command codes
`define CMD_IDLE          8'h00
`define CMD_NVM_READ      8'h03
`define CMD_CONFIG_LOAD   8'h07
`define CMD_KEY_NVM       8'h0B
`define CMD_CRC           8'h12
`define CMD_KEY_FIFO      8'h19

// argument byte counts
`define ARGS_NVM_READ     7'h03
`define ARGS_CONFIG_LOAD  7'h02
`define ARGS_KEY_NVM      7'h02
`define ARGS_KEY_FIFO     7'h0C

// register byte offsets on the APB
`define OFS_COMMAND       12'h000
`define OFS_MAIN_STATUS   12'h004
`define OFS_ERROR_CAUSE   12'h008
`define OFS_REDUNDANCY    12'h00C
`define OFS_PRESET_LOW    12'h010
`define OFS_PRESET_HIGH   12'h014
`define OFS_RESULT_LOW    12'h018
`define OFS_RESULT_HIGH   12'h01C

// main status fields
`define ST_ERR_BIT        0
`define ST_CRC_DONE_BIT   1
`define ST_TX_IRQ_BIT     2
`define ST_BUSY_BIT       3
// error cause fields
`define ERR_KEY_BIT       0
`define ERR_ACCESS_BIT    1
`define ERR_CRC_BIT       3
// redundancy config fields
`define RED_WIDTH8_BIT    0
`define RED_ALGO_BIT      1

// reset values
`define PRESET_LOW_RST    8'h63
`define PRESET_HIGH_RST   8'h63
`define REDUNDANCY_RST    2'h0

// memory and register geometry
`define CONFIG_LEN        8'h20
`define KEY_LEN           8'h0C
`define CFG_REG_FIRST     6'h10
`define CFG_REG_LAST      6'h2F

// crc engine, reflected polynomials and good residues
`define POLY16_REFL       16'h8408
`define POLY8_REFL        8'hB8
`define RESIDUE_ALGO_A    16'h0000
`define RESIDUE_ALGO_B    16'hF0B8

`endif

// ===== design/cmd_unit_pkg.sv
// types shared by the command unit and its surroundings
package cmd_unit_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_ARGS,
        ST_ARGS,
        ST_NVM_REQ,
        ST_NVM_WAIT,
        ST_CRC,
        ST_KEY_CHECK
    } state_e;

    typedef struct packed {
        logic       empty;
        logic       full;
        logic [6:0] level;
        logic [7:0] data;
    } fifo_status_s;

    typedef struct packed {
        logic       ack;
        logic [7:0] data;
    } nvm_rsp_s;

    typedef struct packed {
        logic       en;
        logic [5:0] addr;
        logic [7:0] data;
    } cfg_wr_s;

endpackage

// ===== design/eeprom_crc_key_command_unit.sv
// command unit: nvm read, config load, crc and key loading
//
// How it works
// - read args: address low, high, count
// - read copies count bytes nvm to fifo
// - host starts read; ends after last byte
// - read of key blocks sets access error
// - nvm addresses wrap modulo memory size
// - config load takes two-byte start address
// - config bytes go to registers 10h-2Fh
// - host starts config load; ends itself
// - config copy from key blocks: access error
// - crc eats all fifo bytes, results only
// - crc never ends; waits, idle stops it
// - eight-bit crc fixed degree-eight polynomial
// - sixteen-bit crc fixed degree-sixteen polynomial
// - crc done sets done and transmit irq
// - results and mismatch valid when done
// - errors set summary bit, cause latched
// - key from nvm: address, read, stop
// - bad key format: load anyway, key error
// - key from fifo: twelve bytes, check, stop
`include "cmd_unit_params.svh"
`timescale 1ns/1ns
`default_nettype none

module eeprom_crc_key_command_unit (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       clk_en,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire cmd_unit_pkg::fifo_status_s fifo_in,
    output logic                            fifo_pop,
    output logic                            fifo_wr,
    output logic      [7:0]                 fifo_wdata,
    output logic                            nvm_rd,
    output logic      [8:0]                 nvm_addr,
    input  wire cmd_unit_pkg::nvm_rsp_s     nvm_rsp,
    output cmd_unit_pkg::cfg_wr_s           cfg_wr,
    output logic                            key_load,
    output logic      [47:0]                key_value
);
    import cmd_unit_pkg::*;

    // ==========================================================
    // state
    state_e      state_q;
    logic [7:0]  cmd_q;
    logic [6:0]  need_q;
    logic [6:0]  idx_q;
    logic [7:0]  rem_q;
    logic [8:0]  addr_q;
    logic [5:0]  reg_ptr_q;
    logic [95:0] raw_q;
    logic        pop_q;
    logic        fifo_wr_q;
    logic [7:0]  fifo_wdata_q;
    logic        nvm_rd_q;
    cfg_wr_s     cfg_q;
    logic        key_load_q;
    logic [47:0] key_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [1:0]  redund_q;
    logic [7:0]  preset_lo_q;
    logic [7:0]  preset_hi_q;
    logic [15:0] crc_q;
    logic        done_q;
    logic        irq_q;
    logic        err_q;
    logic        acc_q;
    logic        key_format_error_flag_q;
    logic        crcbad_q;

    // ==========================================================
    // decode and events
    logic        access;
    logic        wr_en;
    logic        start;
    logic        nvm_hit;
    logic        acc_set;
    logic        key_set;
    logic        crc_pop;
    logic        done_d;
    logic        crc_bad;
    logic        mapped;
    logic [15:0] result;
    logic [11:0] key_ok;
    logic [47:0] key_nib;

    assign access  = psel && penable && pready_q;
    assign wr_en   = access && pwrite;
    assign start   = wr_en && (paddr == `OFS_COMMAND);
    assign nvm_hit = (state_q == ST_NVM_WAIT) && nvm_rsp.ack;
    assign acc_set = nvm_hit && (cmd_q != `CMD_KEY_NVM)
                     && (nvm_addr_q_hi() != 2'h0);
    assign key_set = (state_q == ST_KEY_CHECK) && !(&key_ok);
    assign crc_pop = (state_q == ST_CRC) && !fifo_in.empty && !pop_q;
    assign done_d  = (state_q == ST_CRC) && fifo_in.empty && !pop_q;
    assign crc_bad = redund_q[`RED_ALGO_BIT]
                     ? (crc_q != `RESIDUE_ALGO_B)
                     : (crc_q != `RESIDUE_ALGO_A);

    function automatic logic [1:0] nvm_addr_q_hi();
        return addr_q[8:7];
    endfunction

    // each stored key byte holds a nibble and its complement
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++)
        begin : g_key
            assign key_ok[gi] = (raw_q[gi*8+4 +: 4] == ~raw_q[gi*8 +: 4]);
            assign key_nib[gi*4 +: 4] = raw_q[gi*8 +: 4];
        end
    endgenerate

    // reflected lsb-first crc step, 8 or 16 bit wide
    function automatic logic [15:0] crc_step(input logic [15:0] c_in,
                                             input logic [7:0]  d,
                                             input logic        w8);
        logic [15:0] c;
        logic        fb;
        c  = c_in;
        fb = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            fb = c[0] ^ d[i];
            if (w8)
            begin
                c = {8'h00, 1'b0, c[7:1]};
                if (fb)
                    c[7:0] = c[7:0] ^ `POLY8_REFL;
            end
            else
            begin
                c = {1'b0, c[15:1]};
                if (fb)
                    c = c ^ `POLY16_REFL;
            end
        end
        return c;
    endfunction

    always_comb
    begin
        result = redund_q[`RED_ALGO_BIT] ? ~crc_q : crc_q;
        if (redund_q[`RED_WIDTH8_BIT])
            result[15:8] = 8'h00;
    end

    // ==========================================================
    // command sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q      <= ST_IDLE;
            cmd_q        <= `CMD_IDLE;
            need_q       <= 7'h00;
            idx_q        <= 7'h00;
            rem_q        <= 8'h00;
            addr_q       <= 9'h000;
            reg_ptr_q    <= `CFG_REG_FIRST;
            raw_q        <= 96'h0;
            pop_q        <= 1'b0;
            fifo_wr_q    <= 1'b0;
            fifo_wdata_q <= 8'h00;
            nvm_rd_q     <= 1'b0;
            cfg_q        <= '0;
            key_load_q   <= 1'b0;
            key_q        <= 48'h0;
        end
        else if (clk_en)
        begin
            pop_q      <= 1'b0;
            fifo_wr_q  <= 1'b0;
            nvm_rd_q   <= 1'b0;
            cfg_q.en   <= 1'b0;
            key_load_q <= 1'b0;
            if (start)
            begin
                // a new command aborts the running one
                cmd_q     <= pwdata[7:0];
                idx_q     <= 7'h00;
                reg_ptr_q <= `CFG_REG_FIRST;
                unique case (pwdata[7:0])
                    `CMD_NVM_READ:
                    begin
                        need_q  <= `ARGS_NVM_READ;
                        state_q <= ST_WAIT_ARGS;
                    end
                    `CMD_CONFIG_LOAD:
                    begin
                        need_q  <= `ARGS_CONFIG_LOAD;
                        state_q <= ST_WAIT_ARGS;
                    end
                    `CMD_KEY_NVM:
                    begin
                        need_q  <= `ARGS_KEY_NVM;
                        state_q <= ST_WAIT_ARGS;
                    end
                    `CMD_KEY_FIFO:
                    begin
                        need_q  <= `ARGS_KEY_FIFO;
                        state_q <= ST_WAIT_ARGS;
                    end
                    `CMD_CRC:
                        state_q <= ST_CRC;
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE: ;
                    ST_WAIT_ARGS:
                        // nothing is consumed before all args are queued
                        if (fifo_in.level >= need_q)
                            state_q <= ST_ARGS;
                    ST_ARGS:
                        if (!pop_q)
                        begin
                            pop_q <= 1'b1;
                            idx_q <= idx_q + 7'h01;
                            raw_q <= {fifo_in.data, raw_q[95:8]};
                            if (idx_q == 7'h00)
                                addr_q[7:0] <= fifo_in.data;
                            if (idx_q == 7'h01)
                                addr_q[8] <= fifo_in.data[0];
                            if (idx_q == need_q - 7'h01)
                            begin
                                unique case (cmd_q)
                                    `CMD_NVM_READ:
                                    begin
                                        rem_q   <= fifo_in.data;
                                        state_q <= (fifo_in.data == 8'h00)
                                                   ? ST_IDLE : ST_NVM_REQ;
                                    end
                                    `CMD_CONFIG_LOAD:
                                    begin
                                        rem_q   <= `CONFIG_LEN;
                                        state_q <= ST_NVM_REQ;
                                    end
                                    `CMD_KEY_NVM:
                                    begin
                                        rem_q   <= `KEY_LEN;
                                        state_q <= ST_NVM_REQ;
                                    end
                                    default:
                                        state_q <= ST_KEY_CHECK;
                                endcase
                            end
                        end
                    ST_NVM_REQ:
                        // for a read, the fifo must have room before a byte is fetched
                        if (!(cmd_q == `CMD_NVM_READ && fifo_in.full))
                        begin
                            nvm_rd_q <= 1'b1;
                            state_q  <= ST_NVM_WAIT;
                        end
                    ST_NVM_WAIT:
                        if (nvm_rsp.ack)
                        begin
                            rem_q  <= rem_q - 8'h01;
                            addr_q <= addr_q + 9'h001;
                            if (acc_set)
                                state_q <= ST_IDLE;
                            else
                            begin
                                if (cmd_q == `CMD_NVM_READ)
                                begin
                                    fifo_wr_q    <= 1'b1;
                                    fifo_wdata_q <= nvm_rsp.data;
                                end
                                else if (cmd_q == `CMD_CONFIG_LOAD)
                                begin
                                    cfg_q.en   <= 1'b1;
                                    cfg_q.addr <= reg_ptr_q;
                                    cfg_q.data <= nvm_rsp.data;
                                    reg_ptr_q  <= reg_ptr_q + 6'h01;
                                end
                                else
                                    raw_q <= {nvm_rsp.data, raw_q[95:8]};
                                if (rem_q == 8'h01)
                                    state_q <= (cmd_q == `CMD_KEY_NVM)
                                               ? ST_KEY_CHECK
                                               : ST_IDLE;
                                else
                                    state_q <= ST_NVM_REQ;
                            end
                        end
                    ST_CRC:
                        // stays until the host writes another command
                        pop_q <= crc_pop;
                    ST_KEY_CHECK:
                    begin
                        key_load_q <= 1'b1;
                        key_q      <= key_nib;
                        state_q    <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // crc engine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            crc_q <= 16'h0000;
        else if (clk_en)
        begin
            if (start && pwdata[7:0] == `CMD_CRC)
                crc_q <= {preset_hi_q, preset_lo_q};
            else if (crc_pop)
                crc_q <= crc_step(crc_q, fifo_in.data,
                                  redund_q[`RED_WIDTH8_BIT]);
        end
    end

    // ==========================================================
    // status and error flags; except for done, which a start clears, a set wins over a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_q   <= 1'b0;
            irq_q    <= 1'b0;
            err_q    <= 1'b0;
            acc_q    <= 1'b0;
            key_format_error_flag_q <= 1'b0;
            crcbad_q <= 1'b0;
        end
        else if (clk_en)
        begin
            done_q <= done_d && !start;
            if (done_d && !done_q)
                irq_q <= 1'b1;
            else if (wr_en && paddr == `OFS_MAIN_STATUS
                     && pwdata[`ST_TX_IRQ_BIT])
                irq_q <= 1'b0;
            if (acc_set)
                acc_q <= 1'b1;
            else if (start)
                acc_q <= 1'b0;
            if (key_set)
                key_format_error_flag_q <= 1'b1;
            else if (start)
                key_format_error_flag_q <= 1'b0;
            if (done_d && !done_q)
                crcbad_q <= crc_bad;
            else if (start)
                crcbad_q <= 1'b0;
            if (acc_set || key_set || (done_d && !done_q && crc_bad))
                err_q <= 1'b1;
            else if (start)
                err_q <= 1'b0;
        end
    end

    // ==========================================================
    // apb slave, answers in the second access cycle
    always_comb
    begin
        unique case (paddr)
            `OFS_COMMAND, `OFS_MAIN_STATUS, `OFS_ERROR_CAUSE,
            `OFS_REDUNDANCY, `OFS_PRESET_LOW, `OFS_PRESET_HIGH,
            `OFS_RESULT_LOW, `OFS_RESULT_HIGH:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            prdata_q    <= 32'h0;
            redund_q    <= `REDUNDANCY_RST;
            preset_lo_q <= `PRESET_LOW_RST;
            preset_hi_q <= `PRESET_HIGH_RST;
        end
        else if (clk_en)
        begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            prdata_q  <= 32'h0;
            if (psel && penable && !pready_q && !pwrite)
            begin
                unique case (paddr)
                    `OFS_COMMAND:
                        prdata_q[7:0] <= (state_q == ST_IDLE)
                                         ? `CMD_IDLE : cmd_q;
                    `OFS_MAIN_STATUS:
                    begin
                        prdata_q[`ST_ERR_BIT]      <= err_q;
                        prdata_q[`ST_CRC_DONE_BIT] <= done_q;
                        prdata_q[`ST_TX_IRQ_BIT]   <= irq_q;
                        prdata_q[`ST_BUSY_BIT]     <= state_q != ST_IDLE;
                    end
                    `OFS_ERROR_CAUSE:
                    begin
                        prdata_q[`ERR_KEY_BIT]    <= key_format_error_flag_q;
                        prdata_q[`ERR_ACCESS_BIT] <= acc_q;
                        prdata_q[`ERR_CRC_BIT]    <= crcbad_q;
                    end
                    `OFS_REDUNDANCY:
                        prdata_q[1:0] <= redund_q;
                    `OFS_PRESET_LOW:
                        prdata_q[7:0] <= preset_lo_q;
                    `OFS_PRESET_HIGH:
                        prdata_q[7:0] <= preset_hi_q;
                    `OFS_RESULT_LOW:
                        prdata_q[7:0] <= result[7:0];
                    `OFS_RESULT_HIGH:
                        prdata_q[7:0] <= result[15:8];
                    default: ;
                endcase
            end
            if (wr_en && paddr == `OFS_REDUNDANCY)
                redund_q <= pwdata[1:0];
            if (wr_en && paddr == `OFS_PRESET_LOW)
                preset_lo_q <= pwdata[7:0];
            if (wr_en && paddr == `OFS_PRESET_HIGH)
                preset_hi_q <= pwdata[7:0];
        end
    end

    // ==========================================================
    // outputs
    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign fifo_pop   = pop_q;
    assign fifo_wr    = fifo_wr_q;
    assign fifo_wdata = fifo_wdata_q;
    assign nvm_rd     = nvm_rd_q;
    assign nvm_addr   = addr_q;
    assign cfg_wr     = cfg_q;
    assign key_load   = key_load_q;
    assign key_value  = key_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_ARGS_PRESENT: assert property (
        $rose(state_q == ST_ARGS) |-> $past(fifo_in.level) >= need_q)
        else $error("arguments consumed before all were queued");
    AST_KEY_AREA_HIDDEN: assert property (
        clk_en && acc_set && !start |=> !fifo_wr_q && acc_q && err_q)
        else $error("key area byte exposed or not flagged");
    AST_CRC_IRQ: assert property (
        $rose(done_q) |-> irq_q)
        else $error("crc done without transmit irq");
    AST_CRC_NO_FIFO_WRITE: assert property (
        state_q == ST_CRC |-> !fifo_wr_q)
        else $error("crc command wrote into the fifo");
    AST_CFG_RANGE: assert property (
        cfg_q.en |-> cfg_q.addr >= `CFG_REG_FIRST
                     && cfg_q.addr <= `CFG_REG_LAST)
        else $error("config load wrote outside register window");
    AST_READ_ENDS: assert property (
        fifo_wr_q && rem_q == 8'h00 |-> state_q == ST_IDLE)
        else $error("read did not stop after the last byte");
    AST_ERR_SUMMARY: assert property (
        (acc_q || key_format_error_flag_q || crcbad_q) |-> err_q)
        else $error("error cause without summary flag");
    AST_KEY_STOPS: assert property (
        key_load_q |-> $past(state_q == ST_KEY_CHECK)
                       && state_q == ST_IDLE)
        else $error("key load did not end the command");
    AST_ADDR_WRAP: assert property (
        clk_en && nvm_hit && !start |=> addr_q == $past(addr_q) + 9'h001)
        else $error("nvm address did not advance modulo size");

    COV_READ_DONE: cover property (
        fifo_wr_q && rem_q == 8'h00);
    COV_CRC_DONE: cover property ($rose(done_q));
    COV_KEY_BAD: cover property (key_load_q && key_format_error_flag_q);
    COV_CFG_LAST: cover property (cfg_q.en && cfg_q.addr == `CFG_REG_LAST);

endmodule

`default_nettype wire

// ===== verif/nvm_fifo_model.sv
// fifo and nonvolatile memory model facing the command unit
`timescale 1ns/1ns
`default_nettype none
module nvm_fifo_model (
    input  wire logic                 pclk,
    input  wire logic                 fifo_pop,
    input  wire logic                 fifo_wr,
    input  wire logic [7:0]           fifo_wdata,
    input  wire logic                 nvm_rd,
    input  wire logic [8:0]           nvm_addr,
    output cmd_unit_pkg::fifo_status_s fifo_in,
    output cmd_unit_pkg::nvm_rsp_s     nvm_rsp
);
    import cmd_unit_pkg::*;
    logic [7:0] q[$];
    int         wait_n = 0;
    bit         slow = 0;
    initial fifo_in = '{1'b1, 1'b0, 7'h00, 8'hA5};
    initial nvm_rsp = '0;
    function automatic logic [7:0] mem(logic [8:0] a);
        return a[7:0] ^ {7'h2D, a[8]};
    endfunction
    // host side queues argument and data bytes in order
    task automatic push(logic [7:0] b);
        q.push_back(b);
    endtask
    always @(posedge pclk)
    begin
        if (fifo_pop && q.size() > 0)
            void'(q.pop_front());
        if (fifo_wr)
            q.push_back(fifo_wdata);
        fifo_in.empty <= (q.size() == 0);
        fifo_in.full <= (q.size() >= 64);
        fifo_in.level <= 7'(q.size());
        // an empty head toggles between the last byte and its complement
        fifo_in.data <= (q.size() > 0) ? q[0] : ~fifo_in.data;
        // answer alternately fast and slow; data toggles outside ack
        nvm_rsp.ack <= (wait_n == 1);
        nvm_rsp.data <= (wait_n == 1) ? mem(nvm_addr) : ~nvm_rsp.data;
        if (nvm_rd)
            wait_n <= slow ? 3 : 1;
        else if (wait_n > 0)
            wait_n <= wait_n - 1;
        if (nvm_rd)
            slow <= !slow;
    end
endmodule
`default_nettype wire

// ===== verif/eeprom_crc_key_command_unit_test.sv
// self-checking bench of the command unit
`include "cmd_unit_params.svh"
`timescale 1ns/1ns
`default_nettype none
module eeprom_crc_key_command_unit_test;
    import cmd_unit_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, fifo_pop, fifo_wr, nvm_rd, key_load, serr;
    logic [7:0] fifo_wdata, b[$];
    logic [8:0] nvm_addr;
    logic [47:0] key_value, key_exp;
    fifo_status_s fifo_in;
    nvm_rsp_s nvm_rsp;
    cfg_wr_s cfg_wr;
    logic [15:0] exp_q[$], crc;
    int num_errors = 0, comparisons = 0;
    always #5 pclk = ~pclk;
    eeprom_crc_key_command_unit dut (.pclk, .presetn, .clk_en(1'b1),
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fifo_in, .fifo_pop, .fifo_wr, .fifo_wdata, .nvm_rd,
        .nvm_addr, .nvm_rsp, .cfg_wr, .key_load, .key_value);
    nvm_fifo_model m (.pclk, .fifo_pop, .fifo_wr, .fifo_wdata, .nvm_rd,
        .nvm_addr, .fifo_in, .nvm_rsp);
    task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // reflected lsb-first crc reference over one byte
    function automatic logic [15:0] crc_ref(logic [15:0] c, d, p);
        for (int i = 0; i < 8; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? p : 16'h0000);
        return c;
    endfunction
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1);
        rd = prdata;
        serr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic feed(logic [7:0] v[$]);
        foreach (v[i])
        begin
            @(negedge pclk);
            m.push(v[i]);
        end
        @(posedge pclk);
    endtask
    task automatic wait_idle;
        do apb(0, `OFS_MAIN_STATUS, 0);
        while (rd[`ST_BUSY_BIT] !== 0);
    endtask
    // copied bytes land in fifo or registers in the noted order
    always @(posedge pclk)
        if (fifo_wr === 1 || cfg_wr.en === 1)
            check("copied byte", fifo_wr ? {8'h00, fifo_wdata} : {2'b0,
                cfg_wr.addr, cfg_wr.data}, exp_q.pop_front());
    initial
    begin
        #200000;
        num_errors++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'h0B32));
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, `OFS_PRESET_LOW, 0);
        check("preset low", {serr, rd}, 33'h63);
        for (int i = 0; i < 2; i++)
            exp_q.push_back({8'h00, m.mem(9'h07E + 9'(i))});
        apb(1, `OFS_COMMAND, `CMD_NVM_READ);
        feed('{8'h7E, 8'h02, 8'h02});
        wait_idle();
        check("read left", exp_q.size(), 0);
        apb(0, `OFS_COMMAND, 0);
        check("command", rd, 0);
        // drop the bytes the read returned so they are not taken as args
        m.q.delete();
        feed('{8'h80, 8'h00, 8'h01});
        apb(1, `OFS_COMMAND, `CMD_NVM_READ);
        wait_idle();
        check("status err", rd[`ST_ERR_BIT], 1);
        apb(0, `OFS_ERROR_CAUSE, 0);
        check("cause", rd, 32'h2);
        for (int i = 0; i < 32; i++)
            exp_q.push_back({2'b0, 6'h10 + 6'(i), m.mem(9'h010 + 9'(i))});
        feed('{8'h10, 8'h00});
        apb(1, `OFS_COMMAND, `CMD_CONFIG_LOAD);
        wait_idle();
        check("config left", exp_q.size(), 0);
        // model bytes at 080h-08Bh are not all in key format
        feed('{8'h80, 8'h00});
        apb(1, `OFS_COMMAND, `CMD_KEY_NVM);
        wait_idle();
        apb(0, `OFS_ERROR_CAUSE, 0);
        check("key nvm", rd, 1);
        $display("copy tests done");
        for (int k = 0; k < 2; k++)
        begin
            b.delete();
            for (int i = 0; i < 12; i++)
            begin
                key_exp[4*i+:4] = 4'($urandom);
                b.push_back({~key_exp[4*i+:4], key_exp[4*i+:4]});
            end
            if (k == 1)
                b[3] = {b[3][3:0], b[3][3:0]};
            feed(b);
            apb(1, `OFS_COMMAND, `CMD_KEY_FIFO);
            wait_idle();
            if (k == 0)
                check("key", key_value, key_exp);
            apb(0, `OFS_ERROR_CAUSE, 0);
            check("key error", rd, k);
        end
        for (int w = 0; w < 2; w++)
        begin
            crc = w ? 16'h0063 : 16'h6363;
            b.delete();
            for (int i = 0; i < 3; i++)
            begin
                b.push_back(8'($urandom));
                crc = crc_ref(crc, b[i], w ? 16'h00B8 : 16'h8408);
            end
            apb(1, `OFS_REDUNDANCY, w);
            feed(b);
            apb(1, `OFS_COMMAND, `CMD_CRC);
            repeat (3) apb(0, `OFS_MAIN_STATUS, 0);
            check("crc done irq", rd[2:1], 2'b11);
            apb(0, `OFS_RESULT_LOW, 0);
            check("crc low", rd, crc[7:0]);
            apb(0, `OFS_RESULT_HIGH, 0);
            check("crc high", rd, crc[15:8]);
            apb(0, `OFS_ERROR_CAUSE, 0);
            check("crc error", rd, {crc != 16'h0000, 3'b000});
            apb(1, `OFS_COMMAND, `CMD_IDLE);
            apb(0, `OFS_COMMAND, 0);
            check("crc stopped", rd, 0);
        end
        $display("key and crc tests done");
        close_out();
    end
endmodule
`default_nettype wire
